// *** sim/drive_ramp_limiter_props.sv ***
// Port-level assertions of the ramp limiter.
`timescale 1ns/1ns
`default_nettype none
module drive_ramp_limiter_props
(
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        ce,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [15:0] reg_rdata,
  input wire logic [15:0] output_frequency,
  input wire logic        second_ramp_active,
  input wire logic        voltage_limiting,
  input wire logic        current_limiting,
  input wire logic        link_compensation_on
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_limit_exclusive: assert property (!(voltage_limiting && current_limiting))
    else $error("both limiter flags high");
  a_comp_clear: assert property (ce && reg_write && reg_addr == 8'h08
    && reg_wdata == 16'h0000 |=> !link_compensation_on) else $error("compensation kept");
  a_unmapped_zero: assert property (ce && reg_read && reg_addr > 8'h0F
    |=> reg_rdata == 16'h0000) else $error("unmapped read not zero");
  a_rdata_holds: assert property (!(ce && reg_read) |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_freq_settles: assert property ($changed(output_frequency)
    |=> $stable(output_frequency) [*8]) else $error("frequency stepped twice");
  a_ce_freeze: assert property (!ce |=> $stable(output_frequency))
    else $error("frequency moved while frozen");
  a_reset_state: assert property ($rose(rst_n) |-> output_frequency == 16'h0000
    && !second_ramp_active && link_compensation_on) else $error("bad reset state");
  a_status_read: assert property (ce && reg_read && reg_addr == 8'h0E
    |=> reg_rdata[2:0] == {$past(current_limiting), $past(voltage_limiting),
    $past(second_ramp_active)}) else $error("status word differs from flags");
endmodule
bind drive_ramp_limiter drive_ramp_limiter_props drive_ramp_limiter_props_i
(
  .clock, .rst_n, .ce, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
  .output_frequency, .second_ramp_active, .voltage_limiting, .current_limiting,
  .link_compensation_on
);
`default_nettype wire

// *** sim/drive_ramp_limiter_tb.sv ***
// Self-checking testbench of the ramp limiter.
`timescale 1ns/1ns
`default_nettype none
module drive_ramp_limiter_tb;
  // A short tick keeps a 0.1 s ramp at 100 ticks of 100 cycles.
  localparam int TICK = 100;
  logic        clock, rst_n, ce, reg_write, reg_read;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, reference_frequency, volt_set, curr_set, v;
  logic [15:0] link_voltage, output_current, output_frequency;
  logic [2:0]  sel;
  logic        second_ramp_active, voltage_limiting, current_limiting, link_compensation_on;
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          cycles = 0;
  drive_ramp_limiter #(.TICK_CYCLES(TICK)) drive_ramp_limiter_i
  (
    .clock, .rst_n, .ce, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .reference_frequency, .link_voltage, .output_current, .second_ramp_pin(sel[0]),
    .second_ramp_serial(sel[1]), .second_ramp_fieldbus(sel[2]), .output_frequency,
    .second_ramp_active, .voltage_limiting, .current_limiting, .link_compensation_on
  );
  motor_stage_model motor_stage_model_i
  (
    .clock, .volt_set, .curr_set, .link_voltage, .output_current
  );
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // The whole run needs about 28500 cycles.
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic ticks(input int n);
    repeat (n * TICK) @(posedge clock);
  endtask
  // Lets the limiters settle, then measures the travel over ten ticks.
  task automatic slope(input string nm, input logic [15:0] e);
    logic [15:0] f;
    ticks(2);
    #1 f = output_frequency;
    ticks(10);
    #1 chk(nm, output_frequency - f, e);
  endtask
  task automatic flag(input string nm, input logic b, input logic e);
    chk(nm, {15'h0000, b}, {15'h0000, e});
  endtask
  task automatic t_registers();
    logic [15:0] rv [14] = '{16'h0032, 16'h0064, 16'h0032, 16'h0064, 16'h0032, 16'h0032,
      16'h0000, 16'h0000, 16'h0001, 16'h0000, 16'h017C, 16'h0015, 16'h0258, 16'h000E};
    logic [7:0]  ba [8] = '{8'h00, 8'h09, 8'h0A, 8'h07, 8'h0E, 8'h0B, 8'h06, 8'h08};
    logic [15:0] bv [8] = '{16'h0000, 16'h0004, 16'h0144, 16'h0006, 16'hFFFF, 16'h0065,
      16'h0001, 16'h0000};
    logic [15:0] be [8] = '{16'h0032, 16'h0000, 16'h017C, 16'h0000, 16'h0000, 16'h0015,
      16'h0001, 16'h0000};
    for (int i = 0; i < 14; i++)
    begin
      rd(8'(i), v);
      chk("reset value", v, rv[i]);
    end
    rd(8'h20, v);
    chk("unmapped", v, 16'h0000);
    for (int i = 0; i < 8; i++)
    begin
      wr(ba[i], bv[i]);
      rd(ba[i], v);
      chk("write check", v, be[i]);
    end
    flag("compensation", link_compensation_on, 1'b0);
    wr(8'h08, 16'h0001);
    wr(8'h06, 16'h0000);
  endtask
  task automatic t_ramps();
    logic [2:0] code [3] = '{3'h2, 3'h3, 3'h5};
    wr(8'h00, 16'h0001);
    reference_frequency <= 16'h0258;
    ce <= 1'b0;
    repeat (5) @(posedge clock);
    ce <= 1'b1;
    slope("first accel", 16'h003C);
    ticks(100);
    rd(8'h0F, v);
    chk("at reference", v, 16'h0258);
    wr(8'h03, 16'h0002);
    wr(8'h07, 16'h0001);
    reference_frequency <= 16'h0000;
    slope("second decel", 16'hFFE2);
    rd(8'h0E, v);
    chk("status second", v & 16'h0001, 16'h0001);
    for (int i = 0; i < 3; i++)
    begin
      wr(8'h07, {13'h0000, code[i]});
      sel <= 3'h0;
      ticks(3);
      #1 flag("source off", second_ramp_active, 1'b0);
      @(posedge clock);
      sel <= 3'(3'h1 << i);
      ticks(3);
      #1 flag("source on", second_ramp_active, 1'b1);
    end
    wr(8'h07, 16'h0004);
    ticks(3);
    #1 flag("source reserved", second_ramp_active, 1'b0);
  endtask
  task automatic t_limits();
    wr(8'h07, 16'h0000);
    wr(8'h01, 16'h0001);
    wr(8'h04, 16'h0001);
    wr(8'h05, 16'h0001);
    sel <= 3'h0;
    reference_frequency <= 16'h012C;
    ticks(60);
    curr_set <= 16'h001E;
    slope("current slowdown", 16'hFFC4);
    flag("current flag", current_limiting, 1'b1);
    wr(8'h09, 16'h0001);
    volt_set <= 16'h0190;
    slope("voltage speedup", 16'h003C);
    flag("voltage wins", voltage_limiting, 1'b1);
    wr(8'h09, 16'h0002);
    volt_set <= 16'h012C;
    reference_frequency <= 16'h0000;
    slope("current freeze", 16'h0000);
    @(posedge clock);
    curr_set <= 16'h000A;
    volt_set <= 16'h0190;
    slope("voltage freeze", 16'h0000);
    flag("voltage flag", voltage_limiting, 1'b1);
    wr(8'h0A, 16'h01A4);
    volt_set <= 16'h01AE;
    slope("voltage disabled", 16'hFFC4);
    wr(8'h09, 16'h0000);
    wr(8'h0B, 16'h001A);
    curr_set <= 16'h0032;
    ticks(3);
    #1 flag("current enabled", current_limiting, 1'b1);
    wr(8'h0B, 16'h001B);
    ticks(3);
    #1 flag("current disabled", current_limiting, 1'b0);
    wr(8'h06, 16'h0001);
    reference_frequency <= 16'h0258;
    slope("s profile start", 16'h001E);
  endtask
  initial
  begin
    rst_n = 1'b0;
    ce = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reference_frequency = 16'h0000;
    volt_set = 16'h012C;
    curr_set = 16'h000A;
    sel = 3'h0;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    t_registers();
    t_ramps();
    t_limits();
    report_and_stop();
  end
endmodule
`default_nettype wire

// *** sim/motor_stage_model.sv ***
// Model of the motor stage measurement front end.
`timescale 1ns/1ns
`default_nettype none
module motor_stage_model
(
  input  wire logic        clock,
  input  wire logic [15:0] volt_set,
  input  wire logic [15:0] curr_set,
  output logic      [15:0] link_voltage,
  output logic      [15:0] output_current
);
  // Measurements lag one clock, as a real sampling front end would.
  always_ff @(posedge clock)
  begin
    link_voltage   <= volt_set;
    output_current <= curr_set;
  end
endmodule
`default_nettype wire

// *** verilog/drive_ramp_limiter.sv ***
// Output frequency ramp with three time sets, S profile and link limiters.
//
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "ramp_limiter_defines.svh"

module drive_ramp_limiter
#(
  parameter int TICK_CYCLES = `TICK_CYCLES
)
(
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  input  wire logic                   ce,
  input  wire logic [7:0]             reg_addr,
  input  wire logic [15:0]            reg_wdata,
  input  wire logic                   reg_write,
  input  wire logic                   reg_read,
  output logic [15:0]                 reg_rdata,
  input  wire logic [15:0]            reference_frequency,
  input  wire logic [15:0]            link_voltage,
  input  wire logic [15:0]            output_current,
  input  wire logic                   second_ramp_pin,
  input  wire logic                   second_ramp_serial,
  input  wire logic                   second_ramp_fieldbus,
  output logic [15:0]                 output_frequency,
  output logic                        second_ramp_active,
  output logic                        voltage_limiting,
  output logic                        current_limiting,
  output logic                        link_compensation_on
);

  // --------------------------------------------------------------------------
  // Elaboration checks
  // --------------------------------------------------------------------------
  // The divider needs 34 cycles, so a tick must be longer than that.
  if (TICK_CYCLES < 64)
  begin : g_tick_check
    $error("TICK_CYCLES must be at least 64");
  end

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [5:0][15:0]               times;
    logic                           s_profile;
    ramp_limiter_pkg::ramp_source_e source;
    logic                           compensation;
    logic [1:0]                     mode;
    logic [15:0]                    volt_thr;
    logic [15:0]                    curr_thr;
    logic [15:0]                    fmax;
    logic [15:0]                    rated;
    logic                           pin_s1;
    logic                           pin_s2;
    logic [31:0]                    tick_cnt;
    logic [31:0]                    freq_acc;
    logic [15:0]                    start_f;
    logic [15:0]                    target;
    logic                           rising;
    logic                           ramping;
    ramp_limiter_pkg::ramp_phase_e  phase;
    logic                           start;
    logic                           second;
    logic                           vlim;
    logic                           ilim;
    logic [15:0]                    rdata;
  } state_s;

  localparam state_s RESET_STATE = '{
    times:        {`RST_EMERGENCY_TIME, `RST_EMERGENCY_TIME, `RST_DECEL_TIME,
                   `RST_ACCEL_TIME, `RST_DECEL_TIME, `RST_ACCEL_TIME},
    s_profile:    1'h0,
    source:       ramp_limiter_pkg::SRC_FIXED_FIRST,
    compensation: `RST_LINK_COMPENSATION,
    mode:         2'h0,
    volt_thr:     `RST_LINK_VOLTAGE_THR,
    curr_thr:     `RST_OUTPUT_CURRENT_THR,
    fmax:         `RST_MAXIMUM_FREQUENCY,
    rated:        `RST_RATED_CURRENT,
    phase:        ramp_limiter_pkg::PH_WAIT,
    default:      '0
  };

  state_s q;
  state_s d;

  step_div_if div ();

  ramp_step_divider u_divider
  (
    .clock (clock),
    .rst_n (rst_n),
    .ce    (ce),
    .div   (div)
  );

  // --------------------------------------------------------------------------
  // Combinational helpers
  // --------------------------------------------------------------------------
  logic [15:0]                      freq_now;
  logic [15:0]                      ref_clamped;
  logic                             use_second;
  logic                             v_hit;
  logic                             i_hit;
  logic [19:0]                      i_disable_lhs;
  logic [19:0]                      i_disable_rhs;
  ramp_limiter_pkg::ramp_action_e   action;
  logic [15:0]                      new_target;
  logic                             up;
  logic [2:0]                       set_index;
  logic [2:0]                       set_index_q;
  logic [31:0]                      step;
  logic [16:0]                      dist_start;
  logic [16:0]                      dist_end;
  logic [16:0]                      dist_total;
  logic [31:0]                      next_acc;
  logic [31:0]                      goal_acc;
  logic [15:0]                      status;

  assign freq_now    = q.freq_acc[31:16];
  assign ref_clamped = (reference_frequency > q.fmax) ? q.fmax : reference_frequency;

  always_comb
  begin
    case (q.source)
      ramp_limiter_pkg::SRC_FIXED_SECOND:  use_second = 1'b1;
      ramp_limiter_pkg::SRC_DIGITAL_INPUT: use_second = q.pin_s2;
      ramp_limiter_pkg::SRC_SERIAL:        use_second = second_ramp_serial;
      ramp_limiter_pkg::SRC_FIELDBUS:      use_second = second_ramp_fieldbus;
      default:                             use_second = 1'b0;
    endcase
  end

  assign v_hit = (q.volt_thr <= `VOLT_DISABLE_ABOVE) && (link_voltage >= q.volt_thr);

  assign i_disable_lhs = 20'(q.curr_thr) * `CURR_DISABLE_DEN;
  assign i_disable_rhs = 20'(q.rated) * `CURR_DISABLE_NUM;
  assign i_hit = (i_disable_lhs <= i_disable_rhs) && (output_current > q.curr_thr);

  always_comb
  begin
    action = ramp_limiter_pkg::ACT_FOLLOW;
    if (v_hit && !q.mode[0] && (ref_clamped < freq_now))
      action = ramp_limiter_pkg::ACT_HOLD;
    else if (v_hit && q.mode[0])
      action = ramp_limiter_pkg::ACT_SPEEDUP;
    else if (i_hit && q.mode[1] && (ref_clamped != freq_now))
      action = ramp_limiter_pkg::ACT_HOLD;
    else if (i_hit && !q.mode[1])
      action = ramp_limiter_pkg::ACT_SLOWDOWN;
  end

  always_comb
  begin
    case (action)
      ramp_limiter_pkg::ACT_HOLD:     new_target = freq_now;
      ramp_limiter_pkg::ACT_SPEEDUP:  new_target = q.fmax;
      ramp_limiter_pkg::ACT_SLOWDOWN: new_target = 16'h0000;
      default:                        new_target = ref_clamped;
    endcase
  end

  assign up = new_target > freq_now;

  always_comb
  begin
    if (action != ramp_limiter_pkg::ACT_FOLLOW)
      set_index = up ? 3'h4 : 3'h5;
    else if (use_second)
      set_index = up ? 3'h2 : 3'h3;
    else
      set_index = up ? 3'h0 : 3'h1;
  end

  // S profile: ends of the travel at half speed, middle at one and a half.
  // An eighth at each end costs a quarter of the time, so the total matches.
  assign dist_start = q.rising ? 17'(freq_now) - 17'(q.start_f)
                               : 17'(q.start_f) - 17'(freq_now);
  assign dist_end   = q.rising ? 17'(q.target) - 17'(freq_now)
                               : 17'(freq_now) - 17'(q.target);
  assign dist_total = dist_start + dist_end;

  always_comb
  begin
    step = div.quotient;
    if (q.s_profile)
    begin
      if (((20'(dist_start) << 3) < 20'(dist_total)) ||
          ((20'(dist_end) << 3) < 20'(dist_total)))
        step = div.quotient >> 1;
      else
        step = div.quotient + (div.quotient >> 1);
    end
    goal_acc = {q.target, 16'h0000};
    if (q.rising)
    begin
      next_acc = q.freq_acc + step;
      if ((next_acc >= goal_acc) || (next_acc < q.freq_acc))
        next_acc = goal_acc;
    end
    else
    begin
      next_acc = q.freq_acc - step;
      if ((next_acc <= goal_acc) || (next_acc > q.freq_acc))
        next_acc = goal_acc;
    end
  end

  always_comb
  begin
    status                         = 16'h0000;
    status[`STAT_SECOND_RAMP]      = q.second;
    status[`STAT_VOLTAGE_LIMIT]    = q.vlim;
    status[`STAT_CURRENT_LIMIT]    = q.ilim;
    status[`STAT_ACCELERATING]     = q.ramping && q.rising;
    status[`STAT_DECELERATING]     = q.ramping && !q.rising;
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb
  begin
    d        = q;
    d.start  = 1'b0;
    d.pin_s1 = second_ramp_pin;
    d.pin_s2 = q.pin_s1;

    // Out-of-range writes are dropped so the divider never sees a zero time.
    if (reg_write)
    begin
      case (reg_addr)
        `OFS_FIRST_ACCEL_TIME, `OFS_FIRST_DECEL_TIME, `OFS_SECOND_ACCEL_TIME,
        `OFS_SECOND_DECEL_TIME, `OFS_EMERGENCY_ACCEL_TIME, `OFS_EMERGENCY_DECEL_TIME:
          if ((reg_wdata >= `TIME_MIN) && (reg_wdata <= `TIME_MAX))
            d.times[reg_addr[2:0]] = reg_wdata;
        `OFS_CURVE_PROFILE:
          if (reg_wdata[15:1] == 15'h0000)
            d.s_profile = reg_wdata[0];
        `OFS_RAMP_SET_SOURCE:
          if (reg_wdata <= 16'h0005)
            d.source = ramp_limiter_pkg::ramp_source_e'(reg_wdata[2:0]);
        `OFS_LINK_COMPENSATION:
          if (reg_wdata[15:1] == 15'h0000)
            d.compensation = reg_wdata[0];
        `OFS_LIMITER_MODE:
          if (reg_wdata[15:2] == 14'h0000)
            d.mode = reg_wdata[1:0];
        `OFS_LINK_VOLTAGE_THR:
          if ((reg_wdata >= `VOLT_MIN) && (reg_wdata <= `VOLT_MAX))
            d.volt_thr = reg_wdata;
        `OFS_OUTPUT_CURRENT_THR:
          if (reg_wdata <= `CURR_MAX)
            d.curr_thr = reg_wdata;
        `OFS_MAXIMUM_FREQUENCY:
          d.fmax = reg_wdata;
        `OFS_RATED_CURRENT:
          d.rated = reg_wdata;
        default:
          d.rated = q.rated;
      endcase
    end

    if (reg_read)
    begin
      case (reg_addr)
        `OFS_FIRST_ACCEL_TIME, `OFS_FIRST_DECEL_TIME, `OFS_SECOND_ACCEL_TIME,
        `OFS_SECOND_DECEL_TIME, `OFS_EMERGENCY_ACCEL_TIME, `OFS_EMERGENCY_DECEL_TIME:
          d.rdata = q.times[reg_addr[2:0]];
        `OFS_CURVE_PROFILE:      d.rdata = {15'h0000, q.s_profile};
        `OFS_RAMP_SET_SOURCE:    d.rdata = {13'h0000, q.source};
        `OFS_LINK_COMPENSATION:  d.rdata = {15'h0000, q.compensation};
        `OFS_LIMITER_MODE:       d.rdata = {14'h0000, q.mode};
        `OFS_LINK_VOLTAGE_THR:   d.rdata = q.volt_thr;
        `OFS_OUTPUT_CURRENT_THR: d.rdata = q.curr_thr;
        `OFS_MAXIMUM_FREQUENCY:  d.rdata = q.fmax;
        `OFS_RATED_CURRENT:      d.rdata = q.rated;
        `OFS_STATUS_WORD:        d.rdata = status;
        `OFS_OUTPUT_FREQUENCY:   d.rdata = freq_now;
        default:                 d.rdata = 16'h0000;
      endcase
    end

    if (q.tick_cnt >= 32'(TICK_CYCLES - 1))
      d.tick_cnt = 32'h00000000;
    else
      d.tick_cnt = q.tick_cnt + 32'h00000001;

    case (q.phase)
      ramp_limiter_pkg::PH_WAIT:
      begin
        if (q.tick_cnt == 32'h00000000)
        begin
          d.vlim   = v_hit && (q.mode[0] || (ref_clamped < freq_now));
          d.ilim   = i_hit && !d.vlim && (!q.mode[1] || (ref_clamped != freq_now));
          d.second = use_second;
          if (new_target != q.target)
          begin
            d.start_f = freq_now;
            d.target  = new_target;
            d.rising  = up;
          end
          d.ramping = (new_target != freq_now);
          // Step from maximum frequency and ramp time
          if (new_target != freq_now)
          begin
            d.start = 1'b1;
            d.phase = ramp_limiter_pkg::PH_DIVIDE;
          end
        end
      end
      ramp_limiter_pkg::PH_DIVIDE:
      begin
        if (div.done)
        begin
          d.freq_acc = next_acc;
          d.phase    = ramp_limiter_pkg::PH_WAIT;
        end
      end
      default:
        d.phase = ramp_limiter_pkg::PH_WAIT;
    endcase
  end

  // --------------------------------------------------------------------------
  // Divider request
  // --------------------------------------------------------------------------
  assign div.start    = q.start;
  assign div.dividend = {q.fmax, 16'h0000};
  assign div.divisor  = 24'(q.times[set_index_q]) * 24'(`TICKS_PER_TENTH);

  // The set is latched with the request so a mid-divide tick cannot change it.

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      set_index_q <= 3'h0;
    else if (ce && (q.phase == ramp_limiter_pkg::PH_WAIT))
      set_index_q <= set_index;
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      q <= RESET_STATE;
    else if (ce)
      q <= d;
  end

  assign reg_rdata            = q.rdata;
  assign output_frequency     = q.freq_acc[31:16];
  assign second_ramp_active   = q.second;
  assign voltage_limiting     = q.vlim;
  assign current_limiting     = q.ilim;
  assign link_compensation_on = q.compensation;

endmodule
`default_nettype wire

// *** verilog/ramp_limiter_defines.svh ***
// Offsets, reset values, field positions and timing counts of the ramp limiter.
`ifndef RAMP_LIMITER_DEFINES_SVH
`define RAMP_LIMITER_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register word addresses
// ----------------------------------------------------------------------------
`define OFS_FIRST_ACCEL_TIME     8'h00
`define OFS_FIRST_DECEL_TIME     8'h01
`define OFS_SECOND_ACCEL_TIME    8'h02
`define OFS_SECOND_DECEL_TIME    8'h03
`define OFS_EMERGENCY_ACCEL_TIME 8'h04
`define OFS_EMERGENCY_DECEL_TIME 8'h05
`define OFS_CURVE_PROFILE        8'h06
`define OFS_RAMP_SET_SOURCE      8'h07
`define OFS_LINK_COMPENSATION    8'h08
`define OFS_LIMITER_MODE         8'h09
`define OFS_LINK_VOLTAGE_THR     8'h0A
`define OFS_OUTPUT_CURRENT_THR   8'h0B
`define OFS_MAXIMUM_FREQUENCY    8'h0C
`define OFS_RATED_CURRENT        8'h0D
`define OFS_STATUS_WORD          8'h0E
`define OFS_OUTPUT_FREQUENCY     8'h0F

// ----------------------------------------------------------------------------
// Reset values (times in 0.1 s, voltage in V, current in 0.1 A, freq in 0.1 Hz)
// ----------------------------------------------------------------------------
`define RST_ACCEL_TIME           16'h0032
`define RST_DECEL_TIME           16'h0064
`define RST_EMERGENCY_TIME       16'h0032
`define RST_LINK_VOLTAGE_THR     16'h017C
`define RST_RATED_CURRENT        16'h000E
`define RST_OUTPUT_CURRENT_THR   16'h0015
`define RST_MAXIMUM_FREQUENCY    16'h0258
`define RST_LINK_COMPENSATION    1'h1

// ----------------------------------------------------------------------------
// Limits and status word bits
// ----------------------------------------------------------------------------
`define TIME_MIN                 16'h0001
`define TIME_MAX                 16'h270F
`define VOLT_MIN                 16'h0145
`define VOLT_MAX                 16'h01CC
`define VOLT_DISABLE_ABOVE       16'h019A
`define CURR_MAX                 16'h0064
`define CURR_DISABLE_NUM         20'h00013
`define CURR_DISABLE_DEN         20'h0000A
`define STAT_SECOND_RAMP         0
`define STAT_VOLTAGE_LIMIT       1
`define STAT_CURRENT_LIMIT       2
`define STAT_ACCELERATING        3
`define STAT_DECELERATING        4

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLOCK_MHZ                50
`define TICK_TIME_US             1000
`define TICK_CYCLES              (`TICK_TIME_US * `CLOCK_MHZ)
`define TENTH_SECOND_US          100000
`define TICKS_PER_TENTH          (`TENTH_SECOND_US / `TICK_TIME_US)

`endif

// *** verilog/ramp_limiter_pkg.sv ***
// Types shared by the ramp limiter modules.
package ramp_limiter_pkg;

  typedef enum logic [2:0] {
    SRC_FIXED_FIRST,
    SRC_FIXED_SECOND,
    SRC_DIGITAL_INPUT,
    SRC_SERIAL,
    SRC_RESERVED,
    SRC_FIELDBUS
  } ramp_source_e;

  typedef enum logic [1:0] {
    ACT_FOLLOW,
    ACT_HOLD,
    ACT_SPEEDUP,
    ACT_SLOWDOWN
  } ramp_action_e;

  typedef enum logic {
    PH_WAIT,
    PH_DIVIDE
  } ramp_phase_e;

  typedef logic [15:0] word_t;

endpackage

// *** verilog/ramp_step_divider.sv ***
// Sequential restoring divider that turns a ramp time into a per-tick step.
`timescale 1ns/1ns
`default_nettype none
module ramp_step_divider
(
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic ce,
  step_div_if.slave div
);

  typedef struct packed {
    logic [5:0]  cnt;
    logic [24:0] rem;
    logic [31:0] quo;
    logic [23:0] den;
    logic        done;
  } div_state_s;

  div_state_s q;
  div_state_s d;
  logic [24:0] shifted;

  always_comb
  begin
    d       = q;
    d.done  = 1'b0;
    shifted = {q.rem[23:0], q.quo[31]};
    if (div.start)
    begin
      d.cnt = 6'h20;
      d.rem = 25'h0000000;
      d.quo = div.dividend;
      d.den = div.divisor;
    end
    else if (q.cnt != 6'h00)
    begin
      // A zero divisor never arrives: ramp times below one tenth are refused.
      if (shifted >= {1'b0, q.den})
      begin
        d.rem = shifted - {1'b0, q.den};
        d.quo = {q.quo[30:0], 1'b1};
      end
      else
      begin
        d.rem = shifted;
        d.quo = {q.quo[30:0], 1'b0};
      end
      d.cnt  = q.cnt - 6'h01;
      d.done = (q.cnt == 6'h01);
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      q <= '0;
    else if (ce)
      q <= d;
  end

  assign div.done     = q.done;
  assign div.quotient = q.quo;

endmodule
`default_nettype wire

// *** verilog/step_div_if.sv ***
// Request and answer signals between the ramp core and its step divider.
`timescale 1ns/1ns
`default_nettype none
interface step_div_if;
  logic        start;
  logic [31:0] dividend;
  logic [23:0] divisor;
  logic        done;
  logic [31:0] quotient;

  modport master (output start, output dividend, output divisor,
                  input done, input quotient);
  modport slave  (input start, input dividend, input divisor,
                  output done, output quotient);
endinterface
`default_nettype wire
